// file: design/ces_defs.svh
// Constants of the CPU error code supervisor: offsets, fields, codes, timing.
// Assumes a 200 MHz core clock and a 32-bit plain register port.
//
// Behaviour
// - Power-up self-checks fail into fault with code
// - Bad backup flash program gives code 22, fault
// - Invalid program to run gives code 23, stop
// - Invalid I/O parameters give code 24, stop
// - Invalid basic parameters give code 25, stop
// - Module type mismatch at run: code 30
// - Type mismatch sets readable mismatch flag
// - Module removed or added at scan end: 31
// - Attachment change sets readable attachment flag
// - Blown module fuse at scan end: 32
// - Blown fuse sets readable fuse flag
`ifndef CES_DEFS_SVH
`define CES_DEFS_SVH

`define CES_SLOTS 8
`define CES_ADDR_W 8

`define CES_OFS_CTRL 8'h00
`define CES_OFS_STATUS 8'h04
`define CES_OFS_ERR 8'h08
`define CES_OFS_PRESENT 8'h0C
`define CES_OFS_CFG_TYPE 8'h10

`define CES_CTRL_CONT 0
`define CES_ST_STATE_LO 0
`define CES_ST_MISMATCH 2
`define CES_ST_ATTACH 3
`define CES_ST_FUSE 4
`define CES_ST_ERR_LED 5
`define CES_ST_PS_LED 6
`define CES_ERR_SLOT_LO 8
`define CES_ERR_SLOT_VLD 12

`define CES_CTRL_RST 1'h0
`define CES_CFG_TYPE_RST 32'h0

`define CES_CODE_NONE 8'h00
`define CES_CODE_DBUS 8'h02
`define CES_CODE_DRAM 8'h03
`define CES_CODE_RTC 8'h04
`define CES_CODE_PMEM 8'h06
`define CES_CODE_USB 8'h0A
`define CES_CODE_BRAM 8'h0B
`define CES_CODE_BFLASH 8'h0C
`define CES_CODE_FLASH_PROG 8'h16
`define CES_CODE_EXEC_PROG 8'h17
`define CES_CODE_IO_PAR 8'h18
`define CES_CODE_BASIC_PAR 8'h19
`define CES_CODE_TYPE 8'h1E
`define CES_CODE_ATTACH 8'h1F
`define CES_CODE_FUSE 8'h20

`define CES_BLINK_MS 500
`define CES_CLK_KHZ 200000

`endif

// file: design/ces_pkg.sv
// Types of the CPU error code supervisor.
// Assumes ces_defs.svh is on the include path.
`include "ces_defs.svh"
package ces_pkg;
  typedef enum logic [1:0] {
    CES_CHECK = 2'b00,
    CES_STOP = 2'b01,
    CES_RUN = 2'b10,
    CES_FAULT = 2'b11
  } ces_state_e;

  typedef struct packed {
    logic dbus;
    logic dram;
    logic rtc;
    logic pmem;
    logic usb;
    logic bram;
    logic bflash;
  } ces_pwr_s;

  typedef struct packed {
    logic flash_prog;
    logic exec_prog;
    logic io_par;
    logic basic_par;
  } ces_prog_s;

  typedef struct packed {
    logic [7:0] code;
    logic [3:0] slot;
    logic slot_vld;
  } ces_err_s;

  typedef logic [`CES_SLOTS-1:0] ces_slots_t;
endpackage

// file: design/ces_pin_sync.sv
// Three-stage pin synchroniser for slot presence and fuse lines.
// Assumes the pins are asynchronous to core_clk_in.
`timescale 1ns/10ps
`default_nettype none
`include "ces_defs.svh"
module ces_pin_sync (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic [2*`CES_SLOTS-1:0] pins_in,
  output logic [2*`CES_SLOTS-1:0] stable_out
);
  import ces_pkg::*;

  genvar i;
  generate
    for (i = 0; i < 2*`CES_SLOTS; i++) begin : g_bit
      logic ff1_r, ff2_r, ff3_r, stb_r, stb_nxt;
      // A change counts once the second and third stage agree
      always_comb begin
        stb_nxt = (ff2_r == ff3_r) ? ff3_r : stb_r;
      end
      always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
          ff1_r <= 1'h0;
          ff2_r <= 1'h0;
          ff3_r <= 1'h0;
          stb_r <= 1'h0;
        end else begin
          ff1_r <= pins_in[i];
          ff2_r <= ff1_r;
          ff3_r <= ff2_r;
          stb_r <= stb_nxt;
        end
      end
      assign stable_out[i] = stb_r;
    end
  endgenerate
endmodule
`default_nettype wire

// file: design/ces_supervisor.sv
// CPU error code supervisor: self-check sequencing, error codes, LEDs, flags.
// Assumes check results come from same-clock logic; slot pins are asynchronous.
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "ces_defs.svh"
module ces_supervisor #(
  parameter int unsigned BLINK_CYC = `CES_BLINK_MS * `CES_CLK_KHZ
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic [`CES_ADDR_W-1:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rd_data_out,
  input wire ces_pkg::ces_pwr_s pwr_fail_in,
  input wire ces_pkg::ces_prog_s prog_fail_in,
  input wire logic run_req_in,
  input wire logic stop_req_in,
  input wire logic scan_end_in,
  input wire ces_pkg::ces_slots_t slot_present_pin_in,
  input wire ces_pkg::ces_slots_t fuse_blown_pin_in,
  input wire logic [4*`CES_SLOTS-1:0] inst_type_in,
  output ces_pkg::ces_state_e state_out,
  output ces_pkg::ces_err_s err_out,
  output logic led_err_out,
  output logic led_ps_out,
  output logic flag_mismatch_out,
  output logic flag_attach_out,
  output logic flag_fuse_out
);
  import ces_pkg::*;

  ces_slots_t present, fuse;
  ces_state_e st_r, st_nxt;
  ces_err_s err_r, err_nxt;
  logic [2:0] flag_r, flag_nxt, flag_set, flag_clr;
  logic cont_r, cont_nxt;
  logic [31:0] cfg_r, cfg_nxt;
  ces_slots_t snap_r, snap_nxt;
  logic errled_r, errled_nxt, ps_r, ps_nxt, bmode_r, bmode_nxt;
  logic [31:0] bcnt_r, bcnt_nxt;
  logic blink_r, blink_nxt, led_r, led_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic chk_evt, pwr_any, prog_any, mism, attach_chg, fuse_any;
  logic [3:0] mis_slot, att_slot, fuse_slot;

  ces_pin_sync u_sync (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .pins_in({fuse_blown_pin_in, slot_present_pin_in}),
    .stable_out({fuse, present})
  );

  // Slot checks: first offending slot wins
  always_comb begin
    mism = 1'h0;
    attach_chg = 1'h0;
    fuse_any = 1'h0;
    mis_slot = 4'h0;
    att_slot = 4'h0;
    fuse_slot = 4'h0;
    for (int i = `CES_SLOTS - 1; i >= 0; i--) begin
      if (present[i] != (cfg_r[4*i +: 4] != 4'h0) ||
          (present[i] && cfg_r[4*i +: 4] != inst_type_in[4*i +: 4])) begin
        mism = 1'h1;
        mis_slot = 4'(i);
      end
      if (present[i] != snap_r[i]) begin
        attach_chg = 1'h1;
        att_slot = 4'(i);
      end
      if (present[i] && fuse[i]) begin
        fuse_any = 1'h1;
        fuse_slot = 4'(i);
      end
    end
  end

  assign pwr_any = |pwr_fail_in;
  assign prog_any = |prog_fail_in;
  assign chk_evt = (st_r == CES_CHECK) || (st_r == CES_STOP && run_req_in);

  // Operating state, error record and LEDs
  always_comb begin
    st_nxt = st_r;
    err_nxt = err_r;
    snap_nxt = snap_r;
    errled_nxt = errled_r;
    ps_nxt = ps_r;
    bmode_nxt = bmode_r;
    flag_set = 3'h0;
    if (chk_evt && (st_r == CES_CHECK) && pwr_any) begin
      st_nxt = CES_FAULT;
      errled_nxt = 1'h1;
      bmode_nxt = pwr_fail_in.dbus | pwr_fail_in.dram;
      err_nxt.slot = 4'h0;
      err_nxt.slot_vld = 1'h0;
      if (pwr_fail_in.dbus) err_nxt.code = `CES_CODE_DBUS;
      else if (pwr_fail_in.dram) err_nxt.code = `CES_CODE_DRAM;
      else if (pwr_fail_in.rtc) err_nxt.code = `CES_CODE_RTC;
      else if (pwr_fail_in.pmem) err_nxt.code = `CES_CODE_PMEM;
      else if (pwr_fail_in.usb) err_nxt.code = `CES_CODE_USB;
      else if (pwr_fail_in.bram) err_nxt.code = `CES_CODE_BRAM;
      else err_nxt.code = `CES_CODE_BFLASH;
    end else if (chk_evt && prog_any) begin
      st_nxt = prog_fail_in.flash_prog ? CES_FAULT : CES_STOP;
      errled_nxt = 1'h1;
      ps_nxt = 1'h0;
      err_nxt.slot = 4'h0;
      err_nxt.slot_vld = 1'h0;
      if (prog_fail_in.flash_prog) err_nxt.code = `CES_CODE_FLASH_PROG;
      else if (prog_fail_in.exec_prog) err_nxt.code = `CES_CODE_EXEC_PROG;
      else if (prog_fail_in.io_par) err_nxt.code = `CES_CODE_IO_PAR;
      else err_nxt.code = `CES_CODE_BASIC_PAR;
    end else if (st_r == CES_CHECK) begin
      st_nxt = CES_STOP;
    end else if (st_r == CES_STOP && run_req_in) begin
      snap_nxt = present;
      errled_nxt = 1'h0;
      ps_nxt = 1'h0;
      st_nxt = CES_RUN;
      if (mism) begin
        flag_set[0] = 1'h1;
        err_nxt = '{code: `CES_CODE_TYPE, slot: mis_slot, slot_vld: 1'h1};
        st_nxt = cont_r ? CES_RUN : CES_STOP;
        errled_nxt = !cont_r;
        ps_nxt = cont_r;
      end
    end else if (st_r == CES_RUN && stop_req_in) begin
      st_nxt = CES_STOP;
    end else if (st_r == CES_RUN && scan_end_in && (attach_chg || fuse_any)) begin
      st_nxt = cont_r ? CES_RUN : CES_STOP;
      errled_nxt = !cont_r;
      ps_nxt = cont_r;
      if (attach_chg) begin
        flag_set[1] = 1'h1;
        snap_nxt = present;
        err_nxt = '{code: `CES_CODE_ATTACH, slot: att_slot, slot_vld: 1'h1};
      end else begin
        flag_set[2] = 1'h1;
        err_nxt = '{code: `CES_CODE_FUSE, slot: fuse_slot, slot_vld: 1'h1};
      end
    end
  end

  // Error LED blink for the bus and RAM faults
  always_comb begin
    bcnt_nxt = 32'h0;
    blink_nxt = 1'h1;
    if (bmode_r) begin
      blink_nxt = blink_r;
      bcnt_nxt = bcnt_r + 32'h1;
      if (bcnt_r >= BLINK_CYC - 1) begin
        bcnt_nxt = 32'h0;
        blink_nxt = !blink_r;
      end
    end
    // LED pin comes straight from a flop, same level as errled and blink
    led_nxt = errled_nxt & blink_nxt;
  end

  // Register port; status flags clear on write of one, a set wins
  always_comb begin
    cont_nxt = cont_r;
    cfg_nxt = cfg_r;
    flag_clr = 3'h0;
    rd_nxt = 32'h0;
    if (wr_in) begin
      unique case (addr_in)
        `CES_OFS_CTRL: cont_nxt = wr_data_in[`CES_CTRL_CONT];
        `CES_OFS_STATUS: flag_clr = wr_data_in[`CES_ST_FUSE:`CES_ST_MISMATCH];
        `CES_OFS_CFG_TYPE: cfg_nxt = wr_data_in;
        default: ;
      endcase
    end
    if (rd_in) begin
      unique case (addr_in)
        `CES_OFS_CTRL: rd_nxt[`CES_CTRL_CONT] = cont_r;
        `CES_OFS_STATUS: begin
          rd_nxt[`CES_ST_STATE_LO +: 2] = st_r;
          rd_nxt[`CES_ST_FUSE:`CES_ST_MISMATCH] = flag_r;
          rd_nxt[`CES_ST_ERR_LED] = errled_r;
          rd_nxt[`CES_ST_PS_LED] = ps_r;
        end
        `CES_OFS_ERR: begin
          rd_nxt[7:0] = err_r.code;
          rd_nxt[`CES_ERR_SLOT_LO +: 4] = err_r.slot;
          rd_nxt[`CES_ERR_SLOT_VLD] = err_r.slot_vld;
        end
        `CES_OFS_PRESENT: rd_nxt[`CES_SLOTS-1:0] = present;
        `CES_OFS_CFG_TYPE: rd_nxt = cfg_r;
        default: ;
      endcase
    end
    flag_nxt = (flag_r & ~flag_clr) | flag_set;
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      st_r <= CES_CHECK;
      err_r <= '{code: `CES_CODE_NONE, slot: 4'h0, slot_vld: 1'h0};
      snap_r <= '0;
      errled_r <= 1'h0;
      ps_r <= 1'h0;
      bmode_r <= 1'h0;
      bcnt_r <= 32'h0;
      blink_r <= 1'h1;
      led_r <= 1'h0;
      flag_r <= 3'h0;
      cont_r <= `CES_CTRL_RST;
      cfg_r <= `CES_CFG_TYPE_RST;
      rd_r <= 32'h0;
    end else begin
      st_r <= st_nxt;
      err_r <= err_nxt;
      snap_r <= snap_nxt;
      errled_r <= errled_nxt;
      ps_r <= ps_nxt;
      bmode_r <= bmode_nxt;
      bcnt_r <= bcnt_nxt;
      blink_r <= blink_nxt;
      led_r <= led_nxt;
      flag_r <= flag_nxt;
      cont_r <= cont_nxt;
      cfg_r <= cfg_nxt;
      rd_r <= rd_nxt;
    end
  end

  assign rd_data_out = rd_r;
  assign state_out = st_r;
  assign err_out = err_r;
  assign led_err_out = led_r;
  assign led_ps_out = ps_r;
  assign flag_mismatch_out = flag_r[0];
  assign flag_attach_out = flag_r[1];
  assign flag_fuse_out = flag_r[2];

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);

  AST_PWR_DBUS: assert property (
    st_r == CES_CHECK && pwr_fail_in.dbus |=> st_r == CES_FAULT
      && err_r.code == `CES_CODE_DBUS && bmode_r ##1 st_r == CES_FAULT)
    else $error("Data bus failure not taken to blinking fault");
  AST_PWR_BFLASH: assert property (
    st_r == CES_CHECK && pwr_fail_in == 7'h01 |=> st_r == CES_FAULT
      && err_r.code == `CES_CODE_BFLASH && errled_r && !bmode_r)
    else $error("Backup flash failure not coded 12");
  AST_FLASH_PROG: assert property (
    chk_evt && !(st_r == CES_CHECK && pwr_any) && prog_fail_in.flash_prog
      |=> st_r == CES_FAULT && err_r.code == `CES_CODE_FLASH_PROG && led_err_out)
    else $error("Backup flash program fault not coded 22");
  AST_EXEC_PROG: assert property (
    chk_evt && !(st_r == CES_CHECK && pwr_any) && prog_fail_in == 4'h4
      |=> st_r == CES_STOP && err_r.code == `CES_CODE_EXEC_PROG && led_err_out)
    else $error("Invalid program not coded 23 with stop");
  AST_IO_PAR: assert property (
    chk_evt && !(st_r == CES_CHECK && pwr_any) && prog_fail_in == 4'h2
      |=> st_r == CES_STOP && err_r.code == `CES_CODE_IO_PAR)
    else $error("Invalid I/O parameters not coded 24");
  AST_BASIC_PAR: assert property (
    chk_evt && !(st_r == CES_CHECK && pwr_any) && prog_fail_in == 4'h1
      |=> st_r == CES_STOP && err_r.code == `CES_CODE_BASIC_PAR)
    else $error("Invalid basic parameters not coded 25");
  AST_TYPE_MISMATCH: assert property (
    st_r == CES_STOP && run_req_in && !prog_any && mism
      |=> err_r.code == `CES_CODE_TYPE && flag_r[0] && err_r.slot_vld
      && (st_r == CES_RUN) == $past(cont_r) && ps_r == $past(cont_r))
    else $error("Type mismatch handled wrongly");
  AST_MISMATCH_FLAG: assert property (
    $rose(flag_r[0]) |-> $past(st_r) == CES_STOP && $past(mism))
    else $error("Mismatch flag set without a mismatch");
  AST_ATTACH: assert property (
    st_r == CES_RUN && scan_end_in && !stop_req_in && attach_chg
      |=> err_r.code == `CES_CODE_ATTACH && flag_r[1] && snap_r == $past(present)
      && (st_r == CES_STOP) == !$past(cont_r))
    else $error("Attachment change handled wrongly");
  AST_ATTACH_FLAG: assert property (
    flag_r[1] && !(wr_in && addr_in == `CES_OFS_STATUS && wr_data_in[3]) |=> flag_r[1])
    else $error("Attachment flag lost without a clear");
  AST_FUSE: assert property (
    st_r == CES_RUN && scan_end_in && !stop_req_in && !attach_chg && fuse_any
      |=> err_r.code == `CES_CODE_FUSE && flag_r[2] && led_ps_out == $past(cont_r))
    else $error("Blown fuse handled wrongly");
  AST_FUSE_FLAG: assert property (
    $rose(flag_r[2]) |-> $past(fuse_any) && $past(st_r) == CES_RUN)
    else $error("Fuse flag set without a blown fuse");
  AST_ERR_READ: assert property (
    rd_in && addr_in == `CES_OFS_ERR |=> rd_data_out[7:0] == $past(err_r.code)
      && rd_data_out[`CES_ERR_SLOT_LO +: 4] == $past(err_r.slot))
    else $error("Error record read back wrong");
  AST_FAULT_HOLD: assert property (
    st_r == CES_FAULT |=> st_r == CES_FAULT)
    else $error("Fault state left without a reset");
  AST_ERR_SLOT: assert property (
    st_r == CES_RUN && scan_end_in && !stop_req_in && attach_chg |=> err_r.slot_vld)
    else $error("Attachment error recorded without its slot");

  COV_FAULT: cover property (st_r == CES_CHECK ##1 st_r == CES_FAULT);
  COV_RUN_CONT: cover property (st_r == CES_RUN && ps_r ##1 flag_r[1]);
  COV_STOP_MIS: cover property (st_r == CES_STOP && flag_r[0] && errled_r);
  COV_FUSE: cover property ($rose(flag_r[2]));
endmodule
`default_nettype wire

// file: tb/ces_slot_model.sv
// Model of the installed modules: presence, fuse and type pins per slot.
// Assumes the bench sets the wanted layout; pins follow one clock later.
`timescale 1ns/10ps
`default_nettype none
`include "ces_defs.svh"
module ces_slot_model (
  input wire logic core_clk_in,
  input wire logic [`CES_SLOTS-1:0] want_present_in,
  input wire logic [`CES_SLOTS-1:0] want_fuse_in,
  input wire logic [4*`CES_SLOTS-1:0] want_type_in,
  output logic [`CES_SLOTS-1:0] slot_present_pin_out,
  output logic [`CES_SLOTS-1:0] fuse_blown_pin_out,
  output logic [4*`CES_SLOTS-1:0] inst_type_out
);
  always_ff @(posedge core_clk_in) begin
    slot_present_pin_out <= want_present_in;
    // An empty slot has no fuse and no type to report
    fuse_blown_pin_out <= want_fuse_in & want_present_in;
    for (int i = 0; i < `CES_SLOTS; i++) begin
      inst_type_out[4*i +: 4] <= want_present_in[i] ? want_type_in[4*i +: 4] : 4'h0;
    end
  end
endmodule
`default_nettype wire

// file: tb/ces_supervisor_tb_top.sv
// Self-checking bench of the error code supervisor against a bench model.
// Assumes ces_pkg and ces_defs.svh are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "ces_defs.svh"
module ces_supervisor_tb_top;
  import ces_pkg::*;
  logic core_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wr_data_in = 32'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [31:0] rd_data_out;
  ces_pwr_s pwr_fail_in = '0;
  ces_prog_s prog_fail_in = '0;
  logic run_req_in = 1'b0;
  logic stop_req_in = 1'b0;
  logic scan_end_in = 1'b0;
  logic [7:0] want_p = 8'h00;
  logic [7:0] want_f = 8'h00;
  logic [31:0] want_t = 32'h0;
  logic [7:0] pres_pin;
  logic [7:0] fuse_pin;
  logic [31:0] inst_type;
  ces_state_e state_out;
  ces_err_s err_out;
  logic led_err_out;
  logic led_ps_out;
  logic flag_mismatch_out;
  logic flag_attach_out;
  logic flag_fuse_out;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int pc[7] = '{2, 3, 4, 6, 10, 11, 12};

  always #2.5 core_clk_in = ~core_clk_in;

  ces_slot_model ces_slot_model_i (
    .core_clk_in(core_clk_in), .want_present_in(want_p), .want_fuse_in(want_f),
    .want_type_in(want_t), .slot_present_pin_out(pres_pin),
    .fuse_blown_pin_out(fuse_pin), .inst_type_out(inst_type));

  ces_supervisor #(.BLINK_CYC(4)) ces_supervisor_i (
    .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
    .pwr_fail_in(pwr_fail_in), .prog_fail_in(prog_fail_in), .run_req_in(run_req_in),
    .stop_req_in(stop_req_in), .scan_end_in(scan_end_in),
    .slot_present_pin_in(pres_pin), .fuse_blown_pin_in(fuse_pin),
    .inst_type_in(inst_type), .state_out(state_out), .err_out(err_out),
    .led_err_out(led_err_out), .led_ps_out(led_ps_out),
    .flag_mismatch_out(flag_mismatch_out), .flag_attach_out(flag_attach_out),
    .flag_fuse_out(flag_fuse_out));

  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      $display("[ERR] %0t run did not finish in time", $time);
      results();
    end
  end

  // Expected outputs: st and code must match; led and ps of 2 mean either level is accepted
  task automatic chk_out(input int st, input int code, input int led, input int ps);
    tests_run++;
    if (state_out !== 2'(st) || err_out.code !== 8'(code)
        || (led < 2 && led_err_out !== led[0]) || (ps < 2 && led_ps_out !== ps[0])) begin
      err_count++;
      $display("[ERR] %0t state %0d code %0d leds %b%b", $time, state_out, err_out.code,
               led_err_out, led_ps_out);
    end
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic do_reset(input ces_pwr_s p, input ces_prog_s g);
    @(posedge core_clk_in);
    sys_rst_in <= 1'b1;
    pwr_fail_in <= p;
    prog_fail_in <= g;
    repeat (6) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    @(negedge core_clk_in);
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_in <= 1'b1;
    @(posedge core_clk_in);
    wr_in <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge core_clk_in);
    rd_in <= 1'b0;
    @(negedge core_clk_in);
    d = rd_data_out;
  endtask

  // Event pulse: 0 run, 1 stop, 2 end of scan
  task automatic ev(input int k);
    @(posedge core_clk_in);
    run_req_in <= (k == 0);
    stop_req_in <= (k == 1);
    scan_end_in <= (k == 2);
    @(posedge core_clk_in);
    {run_req_in, stop_req_in, scan_end_in} <= 3'b000;
    @(negedge core_clk_in);
  endtask

  function automatic int mm_slot(logic [31:0] c, logic [7:0] p, logic [31:0] t);
    for (int i = 0; i < 8; i++)
      if (p[i] != (c[4*i +: 4] != 4'h0) || (p[i] && c[4*i +: 4] != t[4*i +: 4])) return i;
    return -1;
  endfunction

  initial begin
    logic [6:0] p;
    logic [3:0] g;
    logic [31:0] d;
    logic [31:0] cfg;
    int sl;
    int hi;
    void'($urandom(32'h6893));
    // One fault source per reset, lower-priority sources set at random
    for (int i = 0; i < 11; i++) begin
      p = (i < 7) ? ((7'h40 >> i) | (7'($urandom) & ((7'h40 >> i) - 7'h1))) : 7'h0;
      g = (i < 7) ? 4'($urandom) : ((4'h8 >> (i - 7)) | (4'($urandom) & ((4'h8 >> (i - 7)) - 4'h1)));
      do_reset(p, g);
      chk_out((i < 8) ? 3 : 1, (i < 7) ? pc[i] : 15 + i, (i < 2) ? 2 : 1, 0);
      hi = 0;
      for (int k = 0; k < 12; k++) begin
        @(negedge core_clk_in);
        hi += led_err_out;
      end
      chk_word(32'(i < 2), 32'(hi > 0 && hi < 12));
    end
    do_reset('0, '0);
    chk_out(1, 0, 0, 0);
    reg_rd(`CES_OFS_CTRL, d);
    chk_word(d, 32'h0);
    reg_rd(`CES_OFS_CFG_TYPE, d);
    chk_word(d, 32'h0);
    reg_wr(8'h14, 32'hFFFF_FFFF);
    reg_rd(8'h14, d);
    chk_word(d, 32'h0);
    @(posedge core_clk_in);
    want_p <= 8'($urandom) | 8'h01;
    for (int i = 0; i < 8; i++) want_t[4*i +: 4] <= 4'($urandom_range(1, 15));
    repeat (6) @(posedge core_clk_in);
    for (int i = 0; i < 8; i++) cfg[4*i +: 4] = want_p[i] ? want_t[4*i +: 4] : 4'h0;
    reg_rd(`CES_OFS_PRESENT, d);
    chk_word(d, {24'h0, want_p});
    ev(2);
    chk_out(1, 0, 0, 0);
    @(posedge core_clk_in);
    prog_fail_in <= 4'h2;
    ev(0);
    chk_out(1, 24, 1, 0);
    @(posedge core_clk_in);
    prog_fail_in <= 4'h0;
    sl = $urandom_range(0, 7);
    reg_wr(`CES_OFS_CFG_TYPE, cfg ^ (32'h3 << (4 * sl)));
    ev(0);
    sl = mm_slot(cfg ^ (32'h3 << (4 * sl)), want_p, want_t);
    chk_out(1, 30, 1, 0);
    reg_rd(`CES_OFS_ERR, d);
    chk_word(d, {19'h0, 1'b1, 4'(sl), 8'h1E});
    reg_rd(`CES_OFS_STATUS, d);
    chk_word(d, 32'h25);
    reg_wr(`CES_OFS_STATUS, 32'h1C);
    reg_rd(`CES_OFS_STATUS, d);
    chk_word(d, 32'h21);
    reg_wr(`CES_OFS_CTRL, 32'h1);
    ev(0);
    chk_out(2, 30, 0, 1);
    chk_word({29'h0, flag_mismatch_out, flag_attach_out, flag_fuse_out}, 32'h4);
    ev(1);
    chk_out(1, 30, 0, 1);
    reg_wr(`CES_OFS_CFG_TYPE, cfg);
    ev(0);
    chk_out(2, 30, 0, 0);
    ev(2);
    chk_out(2, 30, 0, 0);
    @(posedge core_clk_in);
    want_p <= want_p ^ (8'h1 << $urandom_range(1, 7));
    repeat (6) @(posedge core_clk_in);
    ev(2);
    chk_out(2, 31, 0, 1);
    chk_word({29'h0, flag_mismatch_out, flag_attach_out, flag_fuse_out}, 32'h6);
    ev(2);
    chk_out(2, 31, 0, 1);
    @(posedge core_clk_in);
    want_f <= 8'h01;
    repeat (6) @(posedge core_clk_in);
    reg_wr(`CES_OFS_CTRL, 32'h0);
    ev(2);
    chk_out(1, 32, 1, 0);
    chk_word({29'h0, flag_mismatch_out, flag_attach_out, flag_fuse_out}, 32'h7);
    results();
  end
endmodule
`default_nettype wire
